// [sync_fifo_pkg.sv]
package sync_fifo_pkg;

   // data path and offset register geometry
   localparam int DATA_W = 9;
   localparam int OFS_W = 8;
   localparam int OFS_REGS = 4;

   // supported address widths: 512, 1024, 2048 and 4096 words
   localparam int ADDR_W_MIN = 9;
   localparam int ADDR_W_MAX = 12;
   localparam int PTR_W_MAX = ADDR_W_MAX + 1;

   // offset register reset values: both thresholds default to 7 words
   localparam logic [OFS_W-1:0] EMPTY_OFS_LO_RST = 8'h07;
   localparam logic [OFS_W-1:0] EMPTY_OFS_HI_RST = 8'h00;
   localparam logic [OFS_W-1:0] FULL_OFS_LO_RST = 8'h07;
   localparam logic [OFS_W-1:0] FULL_OFS_HI_RST = 8'h00;

   // data output value after reset
   localparam logic [DATA_W-1:0] DATA_OUT_RST = 9'h000;

   // offset register index, in load/read sequence order
   typedef enum logic [1:0] {
      SEL_EMPTY_LO = 2'b00,
      SEL_EMPTY_HI = 2'b01,
      SEL_FULL_LO = 2'b10,
      SEL_FULL_HI = 2'b11
   } ofs_sel_e;

   // role of the dual-purpose write enable / load input
   typedef enum logic {
      MODE_LOAD = 1'b0,
      MODE_TWO_WRITE_ENABLES = 1'b1
   } pin_mode_e;

   // next register in the offset sequence, wrapping to the first
   function automatic ofs_sel_e ofs_sel_next(input ofs_sel_e sel);
      ofs_sel_next = ofs_sel_e'(sel + 2'h1);
   endfunction : ofs_sel_next

   // binary to gray, zero-extended to the widest pointer
   function automatic logic [PTR_W_MAX-1:0] bin2gray(input logic [PTR_W_MAX-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction : bin2gray

   // gray to binary, zero-extended to the widest pointer
   function automatic logic [PTR_W_MAX-1:0] gray2bin(input logic [PTR_W_MAX-1:0] g);
      logic [PTR_W_MAX-1:0] b;
      b = g;
      for (int i = PTR_W_MAX - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      gray2bin = b;
   endfunction : gray2bin

endpackage : sync_fifo_pkg

// [fifo_dual_port_ram.sv]
`timescale 1ns/10ps
module fifo_dual_port_ram
   import sync_fifo_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_MIN
) (
   // write port
   input wire logic wr_clk_in,
   input wire logic wr_en_in,
   input wire logic [ADDR_W-1:0] wr_addr_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   // read port, combinational
   input wire logic [ADDR_W-1:0] rd_addr_in,
   output logic [DATA_W-1:0] rd_data_out
);

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // store one word per enabled write edge
   always_ff @(posedge wr_clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // read side is captured by the caller's output register
   assign rd_data_out = mem[rd_addr_in];

endmodule : fifo_dual_port_ram

// [sync_fifo_prog_flags.sv]
`timescale 1ns/10ps
module sync_fifo_prog_flags
   import sync_fifo_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_MIN
) (
   // write side clock and shared reset
   input wire logic CLK_SYS_IN,
   input wire logic RESET_N_IN,
   // write side controls and data
   input wire logic WRITE_ENABLE_A_N_IN,
   input wire logic WRITE_ENABLE_B_OR_LOAD_IN,
   input wire logic [DATA_W-1:0] DATA_IN,
   // read side clock and controls
   input wire logic READ_CLK_IN,
   input wire logic READ_ENABLE_A_N_IN,
   input wire logic READ_ENABLE_B_N_IN,
   // read side data
   output logic [DATA_W-1:0] DATA_OUT,
   // write side flags
   output logic FULL_FLAG_N_OUT,
   output logic ALMOST_FULL_FLAG_N_OUT,
   // read side flags
   output logic EMPTY_FLAG_N_OUT,
   output logic ALMOST_EMPTY_FLAG_N_OUT
);

   localparam int PTR_W = ADDR_W + 1;
   localparam logic [PTR_W-1:0] DEPTH = PTR_W'(1) << ADDR_W;
   localparam logic [PTR_W-1:0] PTR_ZERO = '0;
   localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

   // ------------------------------------------------------------------
   // reset synchronisers, one per clock domain
   // ------------------------------------------------------------------
   logic wr_rst_meta_n;
   logic wr_rst_sync_n;
   logic rd_rst_meta_n;
   logic rd_rst_sync_n;
   logic wr_rst;
   logic rd_rst;

   // reset pin into the write clock domain
   always_ff @(posedge CLK_SYS_IN) begin
      wr_rst_meta_n <= RESET_N_IN;
      wr_rst_sync_n <= wr_rst_meta_n;
   end

   // reset pin into the read clock domain
   always_ff @(posedge READ_CLK_IN) begin
      rd_rst_meta_n <= RESET_N_IN;
      rd_rst_sync_n <= rd_rst_meta_n;
   end

   assign wr_rst = !wr_rst_sync_n;
   assign rd_rst = !rd_rst_sync_n;

   // ------------------------------------------------------------------
   // write domain state
   // ------------------------------------------------------------------
   pin_mode_e mode_q;
   logic [PTR_W-1:0] wptr_q;
   logic [PTR_W-1:0] wptr_d;
   logic [PTR_W-1:0] wptr_gray_q;
   logic [PTR_W-1:0] rptr_gray_q;
   logic [PTR_W-1:0] rptr_gray_meta_q;
   logic [PTR_W-1:0] rptr_gray_sync_q;
   logic [PTR_W-1:0] rptr_wr_bin;
   logic [PTR_W-1:0] used_wr;
   logic [OFS_W-1:0] ofs_q [0:OFS_REGS-1];
   ofs_sel_e wr_sel_q;
   logic full_n_q;
   logic almost_full_n_q;
   logic wr_fire;
   logic ofs_wr;
   logic [ADDR_W-1:0] full_ofs;
   logic [PTR_W-1:0] full_level;
   logic [PTR_W_MAX-1:0] wptr_gray_wide;
   logic [PTR_W_MAX-1:0] rptr_bin_wide;
   logic [2*OFS_W-1:0] full_ofs_word;
   logic full_next_n;
   logic almost_full_next_n;

   // role of the dual-purpose pin, caught while reset is held
   always_ff @(posedge CLK_SYS_IN) begin
      if (wr_rst) begin
         mode_q <= WRITE_ENABLE_B_OR_LOAD_IN ? MODE_TWO_WRITE_ENABLES
                                             : MODE_LOAD;
      end
   end

   // fifo write: enable a low, second enable or load select high, room left
   assign wr_fire = !WRITE_ENABLE_A_N_IN && WRITE_ENABLE_B_OR_LOAD_IN
                    && full_n_q;

   // offset write: load mode, load select low, enable a low
   assign ofs_wr = (mode_q == MODE_LOAD) && !WRITE_ENABLE_B_OR_LOAD_IN
                   && !WRITE_ENABLE_A_N_IN;

   // next write pointer
   assign wptr_d = wr_fire ? (wptr_q + PTR_ONE) : wptr_q;

   // gray copy of the next write pointer, one bit moves per write
   assign wptr_gray_wide = bin2gray(PTR_W_MAX'(wptr_d));

   // write pointer and its gray copy for the read side
   always_ff @(posedge CLK_SYS_IN) begin
      if (wr_rst) begin
         wptr_q <= PTR_ZERO;
         wptr_gray_q <= PTR_ZERO;
      end else begin
         wptr_q <= wptr_d;
         wptr_gray_q <= wptr_gray_wide[PTR_W-1:0];
      end
   end

   // read pointer brought over from the read clock, two stages
   always_ff @(posedge CLK_SYS_IN) begin
      if (wr_rst) begin
         rptr_gray_meta_q <= PTR_ZERO;
         rptr_gray_sync_q <= PTR_ZERO;
      end else begin
         rptr_gray_meta_q <= rptr_gray_q;
         rptr_gray_sync_q <= rptr_gray_meta_q;
      end
   end

   // synchronised read pointer back to binary
   assign rptr_bin_wide = gray2bin(PTR_W_MAX'(rptr_gray_sync_q));
   assign rptr_wr_bin = rptr_bin_wide[PTR_W-1:0];

   // words held as seen from the write side, after this edge's write
   assign used_wr = wptr_d - rptr_wr_bin;

   // full offset m, trimmed to the address width
   assign full_ofs_word = {ofs_q[SEL_FULL_HI], ofs_q[SEL_FULL_LO]};
   assign full_ofs = full_ofs_word[ADDR_W-1:0];
   assign full_level = DEPTH - PTR_W'(full_ofs);

   // flag levels for this edge, compared against the word count
   assign full_next_n = (used_wr != DEPTH);
   assign almost_full_next_n = (used_wr < full_level);

   // full and almost-full flags, one flip-flop on the write clock
   always_ff @(posedge CLK_SYS_IN) begin
      if (wr_rst) begin
         full_n_q <= 1'b1;
         almost_full_n_q <= 1'b1;
      end else begin
         full_n_q <= full_next_n;
         almost_full_n_q <= almost_full_next_n;
      end
   end

   // offset registers, loaded in sequence while in load mode
   always_ff @(posedge CLK_SYS_IN) begin
      if (wr_rst) begin
         ofs_q[SEL_EMPTY_LO] <= EMPTY_OFS_LO_RST;
         ofs_q[SEL_EMPTY_HI] <= EMPTY_OFS_HI_RST;
         ofs_q[SEL_FULL_LO] <= FULL_OFS_LO_RST;
         ofs_q[SEL_FULL_HI] <= FULL_OFS_HI_RST;
      end else if (ofs_wr) begin
         ofs_q[wr_sel_q] <= DATA_IN[OFS_W-1:0];
      end
   end

   // write sequence position, kept while normal operation resumes
   always_ff @(posedge CLK_SYS_IN) begin
      if (wr_rst) begin
         wr_sel_q <= SEL_EMPTY_LO;
      end else if (ofs_wr) begin
         wr_sel_q <= ofs_sel_next(wr_sel_q);
      end
   end

   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] ram_rd_data;
   logic [PTR_W-1:0] rptr_q;

   // word array with a write port on the write clock
   fifo_dual_port_ram #(
      .ADDR_W(ADDR_W)
   ) u_ram (
      .wr_clk_in(CLK_SYS_IN),
      .wr_en_in(wr_fire),
      .wr_addr_in(wptr_q[ADDR_W-1:0]),
      .wr_data_in(DATA_IN),
      .rd_addr_in(rptr_q[ADDR_W-1:0]),
      .rd_data_out(ram_rd_data)
   );

   // ------------------------------------------------------------------
   // read domain state
   // ------------------------------------------------------------------
   logic mode_load_meta_q;
   logic mode_load_rd_q;
   logic load_pin_meta_q;
   logic load_pin_rd_q;
   logic [PTR_W-1:0] rptr_d;
   logic [PTR_W-1:0] wptr_gray_meta_q;
   logic [PTR_W-1:0] wptr_gray_sync_q;
   logic [PTR_W-1:0] wptr_rd_bin;
   logic [PTR_W-1:0] used_rd;
   logic [ADDR_W-1:0] empty_ofs;
   ofs_sel_e rd_sel_q;
   logic empty_n_q;
   logic almost_empty_n_q;
   logic [DATA_W-1:0] data_out_q;
   logic rd_en;
   logic rd_fire;
   logic ofs_rd;
   logic [PTR_W_MAX-1:0] rptr_gray_wide;
   logic [PTR_W_MAX-1:0] wptr_bin_wide;
   logic [2*OFS_W-1:0] empty_ofs_word;
   logic empty_next_n;
   logic almost_empty_next_n;

   // load mode and load select brought over from the write side
   always_ff @(posedge READ_CLK_IN) begin
      mode_load_meta_q <= (mode_q == MODE_LOAD);
      mode_load_rd_q <= mode_load_meta_q;
      load_pin_meta_q <= WRITE_ENABLE_B_OR_LOAD_IN;
      load_pin_rd_q <= load_pin_meta_q;
   end

   // both read enables low
   assign rd_en = !READ_ENABLE_A_N_IN && !READ_ENABLE_B_N_IN;

   // fifo read: not empty, and load select high when in load mode
   assign rd_fire = rd_en && empty_n_q
                    && (!mode_load_rd_q || load_pin_rd_q);

   // offset read: load mode with load select low
   assign ofs_rd = rd_en && mode_load_rd_q && !load_pin_rd_q;

   // next read pointer, same order as the write pointer
   assign rptr_d = rd_fire ? (rptr_q + PTR_ONE) : rptr_q;

   // gray copy of the next read pointer, one bit moves per read
   assign rptr_gray_wide = bin2gray(PTR_W_MAX'(rptr_d));

   // read pointer and its gray copy for the write side
   always_ff @(posedge READ_CLK_IN) begin
      if (rd_rst) begin
         rptr_q <= PTR_ZERO;
         rptr_gray_q <= PTR_ZERO;
      end else begin
         rptr_q <= rptr_d;
         rptr_gray_q <= rptr_gray_wide[PTR_W-1:0];
      end
   end

   // write pointer brought over from the write clock, two stages
   always_ff @(posedge READ_CLK_IN) begin
      if (rd_rst) begin
         wptr_gray_meta_q <= PTR_ZERO;
         wptr_gray_sync_q <= PTR_ZERO;
      end else begin
         wptr_gray_meta_q <= wptr_gray_q;
         wptr_gray_sync_q <= wptr_gray_meta_q;
      end
   end

   // synchronised write pointer back to binary
   assign wptr_bin_wide = gray2bin(PTR_W_MAX'(wptr_gray_sync_q));
   assign wptr_rd_bin = wptr_bin_wide[PTR_W-1:0];

   // unread words as seen from the read side, after this edge's read
   assign used_rd = wptr_rd_bin - rptr_d;

   // empty offset n, trimmed to the address width
   assign empty_ofs_word = {ofs_q[SEL_EMPTY_HI], ofs_q[SEL_EMPTY_LO]};
   assign empty_ofs = empty_ofs_word[ADDR_W-1:0];

   // flag levels for this edge, compared against the word count
   assign empty_next_n = (used_rd != PTR_ZERO);
   assign almost_empty_next_n = (used_rd > PTR_W'(empty_ofs));

   // empty and almost-empty flags, one flip-flop on the read clock
   always_ff @(posedge READ_CLK_IN) begin
      if (rd_rst) begin
         empty_n_q <= 1'b0;
         almost_empty_n_q <= 1'b0;
      end else begin
         empty_n_q <= empty_next_n;
         almost_empty_n_q <= almost_empty_next_n;
      end
   end

   // output register: fifo word or offset byte, otherwise held
   always_ff @(posedge READ_CLK_IN) begin
      if (rd_rst) begin
         data_out_q <= DATA_OUT_RST;
      end else if (rd_fire) begin
         data_out_q <= ram_rd_data;
      end else if (ofs_rd) begin
         data_out_q <= {1'b0, ofs_q[rd_sel_q]};
      end
   end

   // read sequence position, same order and wrap as the writes
   always_ff @(posedge READ_CLK_IN) begin
      if (rd_rst) begin
         rd_sel_q <= SEL_EMPTY_LO;
      end else if (ofs_rd) begin
         rd_sel_q <= ofs_sel_next(rd_sel_q);
      end
   end

   // ------------------------------------------------------------------
   // outputs, all from flip-flops
   // ------------------------------------------------------------------
   assign DATA_OUT = data_out_q;
   assign FULL_FLAG_N_OUT = full_n_q;
   assign ALMOST_FULL_FLAG_N_OUT = almost_full_n_q;
   assign EMPTY_FLAG_N_OUT = empty_n_q;
   assign ALMOST_EMPTY_FLAG_N_OUT = almost_empty_n_q;

endmodule : sync_fifo_prog_flags

// [sync_fifo_prog_flags_assertions.sv]
`timescale 1ns/10ps
module sync_fifo_prog_flags_assertions
   import sync_fifo_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_MIN
) (
   // clocks and reset
   input wire logic CLK_SYS_IN,
   input wire logic READ_CLK_IN,
   input wire logic RESET_N_IN,
   // write and read controls
   input wire logic WRITE_ENABLE_A_N_IN,
   input wire logic WRITE_ENABLE_B_OR_LOAD_IN,
   input wire logic [DATA_W-1:0] DATA_IN,
   input wire logic READ_ENABLE_A_N_IN,
   input wire logic READ_ENABLE_B_N_IN,
   // data and flags
   input wire logic [DATA_W-1:0] DATA_OUT,
   input wire logic FULL_FLAG_N_OUT,
   input wire logic ALMOST_FULL_FLAG_N_OUT,
   input wire logic EMPTY_FLAG_N_OUT,
   input wire logic ALMOST_EMPTY_FLAG_N_OUT
);
   logic two_en_q;
   logic wr_try;
   logic rd_try;
   // pin role latched while reset is held
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RESET_N_IN) begin
         two_en_q <= WRITE_ENABLE_B_OR_LOAD_IN;
      end
   end
   // attempted transfers
   assign wr_try = !WRITE_ENABLE_A_N_IN && WRITE_ENABLE_B_OR_LOAD_IN;
   assign rd_try = !READ_ENABLE_A_N_IN && !READ_ENABLE_B_N_IN;
   property p_rst_vals;
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) $rose(RESET_N_IN) |-> FULL_FLAG_N_OUT
         && ALMOST_FULL_FLAG_N_OUT && !EMPTY_FLAG_N_OUT && !ALMOST_EMPTY_FLAG_N_OUT
         && DATA_OUT == DATA_OUT_RST;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("bad values after reset");
   property p_empty_ae;
      @(posedge READ_CLK_IN) disable iff (!RESET_N_IN) !EMPTY_FLAG_N_OUT |-> !ALMOST_EMPTY_FLAG_N_OUT;
   endproperty
   a_empty_ae: assert property (p_empty_ae) else $error("empty without almost-empty");
   property p_full_af;
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) !FULL_FLAG_N_OUT |-> !ALMOST_FULL_FLAG_N_OUT;
   endproperty
   a_full_af: assert property (p_full_af) else $error("full without almost-full");
   property p_hold_a;
      @(posedge READ_CLK_IN) disable iff (!RESET_N_IN) READ_ENABLE_A_N_IN |=> $stable(DATA_OUT);
   endproperty
   a_hold_a: assert property (p_hold_a) else $error("output moved, enable a off");
   property p_hold_b;
      @(posedge READ_CLK_IN) disable iff (!RESET_N_IN) READ_ENABLE_B_N_IN |=> $stable(DATA_OUT);
   endproperty
   a_hold_b: assert property (p_hold_b) else $error("output moved, enable b off");
   property p_empty_hold;
      @(posedge READ_CLK_IN) disable iff (!RESET_N_IN)
         two_en_q && !EMPTY_FLAG_N_OUT |=> $stable(DATA_OUT);
   endproperty
   a_empty_hold: assert property (p_empty_hold) else $error("read taken while empty");
   property p_full_fall;
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN) $fell(FULL_FLAG_N_OUT) |-> $past(wr_try);
   endproperty
   a_full_fall: assert property (p_full_fall) else $error("full without write");
   property p_ae_fall;
      @(posedge READ_CLK_IN) disable iff (!RESET_N_IN)
         two_en_q && $fell(ALMOST_EMPTY_FLAG_N_OUT) |-> $past(rd_try);
   endproperty
   a_ae_fall: assert property (p_ae_fall) else $error("almost-empty without read");
   property p_af_fall;
      @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
         two_en_q && $fell(ALMOST_FULL_FLAG_N_OUT) |-> $past(wr_try);
   endproperty
   a_af_fall: assert property (p_af_fall) else $error("almost-full without write");
   // main scenarios
   c_full: cover property (@(posedge CLK_SYS_IN) !FULL_FLAG_N_OUT);
   c_fill: cover property (@(posedge READ_CLK_IN) $rose(EMPTY_FLAG_N_OUT));
   c_ofs_rd: cover property (@(posedge READ_CLK_IN) !two_en_q && rd_try);
endmodule : sync_fifo_prog_flags_assertions
bind sync_fifo_prog_flags sync_fifo_prog_flags_assertions #(.ADDR_W(ADDR_W))
   i_sync_fifo_prog_flags_assertions (.CLK_SYS_IN, .READ_CLK_IN, .RESET_N_IN,
   .WRITE_ENABLE_A_N_IN, .WRITE_ENABLE_B_OR_LOAD_IN, .DATA_IN, .READ_ENABLE_A_N_IN,
   .READ_ENABLE_B_N_IN, .DATA_OUT, .FULL_FLAG_N_OUT, .ALMOST_FULL_FLAG_N_OUT,
   .EMPTY_FLAG_N_OUT, .ALMOST_EMPTY_FLAG_N_OUT);

// [fifo_reader_model.sv]
`timescale 1ns/10ps
module fifo_reader_model
   import sync_fifo_pkg::*;
(
   // read clock and data
   input wire logic clk_in,
   input wire logic [DATA_W-1:0] data_in,
   // read enables
   output logic ren_a_n_out,
   output logic ren_b_n_out
);
   logic [DATA_W-1:0] got_q[$];
   // enables idle high
   initial begin
      ren_a_n_out = 1'b1;
      ren_b_n_out = 1'b1;
   end
   // back-to-back reads, b_n high holds the output
   task automatic read_words(input int n, input logic b_n);
      got_q.delete();
      @(negedge clk_in);
      ren_a_n_out = 1'b0;
      ren_b_n_out = b_n;
      repeat (n) begin
         @(negedge clk_in);
         got_q.push_back(data_in);
      end
      ren_a_n_out = 1'b1;
      ren_b_n_out = 1'b1;
   endtask : read_words
endmodule : fifo_reader_model

// [sync_fifo_prog_flags_bench.sv]
`timescale 1ns/10ps
module sync_fifo_prog_flags_bench
   import sync_fifo_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wen_a_n = 1'b1;
   logic wen_b_ld = 1'b1;
   logic [DATA_W-1:0] din = 9'h000;
   logic ren_a_n;
   logic ren_b_n;
   logic [DATA_W-1:0] dout;
   logic full_n, afull_n, empty_n, aempty_n;
   logic [DATA_W-1:0] flags;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   // single clock drives both sides
   always #10 clk = ~clk;
   assign flags = {5'h00, full_n, afull_n, empty_n, aempty_n};
   sync_fifo_prog_flags #(.ADDR_W(9)) i_sync_fifo_prog_flags (.CLK_SYS_IN(clk),
      .RESET_N_IN(rst_n), .WRITE_ENABLE_A_N_IN(wen_a_n), .WRITE_ENABLE_B_OR_LOAD_IN(wen_b_ld),
      .DATA_IN(din), .READ_CLK_IN(clk), .READ_ENABLE_A_N_IN(ren_a_n),
      .READ_ENABLE_B_N_IN(ren_b_n), .DATA_OUT(dout), .FULL_FLAG_N_OUT(full_n),
      .ALMOST_FULL_FLAG_N_OUT(afull_n), .EMPTY_FLAG_N_OUT(empty_n),
      .ALMOST_EMPTY_FLAG_N_OUT(aempty_n));
   fifo_reader_model i_fifo_reader_model (.clk_in(clk), .data_in(dout),
      .ren_a_n_out(ren_a_n), .ren_b_n_out(ren_b_n));
   // verdict and end of run
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   // compare seen against expected
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // n back-to-back writes of counting data
   task automatic wr(input int n, input logic [DATA_W-1:0] first);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         wen_a_n = 1'b0;
         din = first + DATA_W'(i);
      end
      @(negedge clk);
      wen_a_n = 1'b1;
   endtask : wr
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle
   // reset for 3 cycles, pin role chosen by mode; called off the rising edge
   task automatic do_reset(input logic mode);
      rst_n = 1'b0;
      wen_b_ld = mode;
      idle(3);
      rst_n = 1'b1;
      idle(4);
      check(dout, DATA_OUT_RST);
      check(flags, 9'h00C);
   endtask : do_reset
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         $display("CHECK FAILED at %0t: timeout", $time);
         end_sim();
      end
   end
   initial begin
      do_reset(1'b1);
      i_fifo_reader_model.read_words(2, 1'b0);
      check(dout, 9'h000);
      wr(7, 9'h101);
      idle(4);
      check(flags, 9'h00E);
      wr(1, 9'h108);
      idle(4);
      check(flags, 9'h00F);
      i_fifo_reader_model.read_words(3, 1'b1);
      check(dout, 9'h000);
      i_fifo_reader_model.read_words(8, 1'b0);
      for (int i = 0; i < 8; i++) check(i_fifo_reader_model.got_q[i], 9'h101 + 9'(i));
      idle(2);
      check(flags, 9'h00C);
      $display("basic flow done");
      wr(504, 9'h000);
      idle(4);
      check(flags, 9'h00F);
      wr(1, 9'h1F8);
      check(flags, 9'h00B);
      wr(8, 9'h1F9);
      check(flags, 9'h003);
      wr(1, 9'h155);
      check(flags, 9'h003);
      i_fifo_reader_model.read_words(1, 1'b0);
      check(i_fifo_reader_model.got_q[0], 9'h000);
      idle(4);
      check(flags, 9'h00B);
      i_fifo_reader_model.read_words(512, 1'b0);
      for (int i = 0; i < 511; i++) check(i_fifo_reader_model.got_q[i], 9'(i + 1));
      check(i_fifo_reader_model.got_q[511], 9'h1FF);
      check(flags, 9'h00C);
      $display("fill and drain done");
      do_reset(1'b0);
      wr(1, 9'h009);
      wr(1, 9'h006);
      wen_b_ld = 1'b1;
      idle(3);
      wen_b_ld = 1'b0;
      wr(1, 9'h003);
      wr(1, 9'h000);
      wr(1, 9'h002);
      idle(3);
      i_fifo_reader_model.read_words(4, 1'b0);
      check(i_fifo_reader_model.got_q[0], 9'h002);
      check(i_fifo_reader_model.got_q[1], 9'h006);
      check(i_fifo_reader_model.got_q[2], 9'h003);
      check(i_fifo_reader_model.got_q[3], 9'h000);
      $display("offset access done");
      wen_b_ld = 1'b1;
      idle(3);
      wr(2, 9'h010);
      idle(4);
      check(flags, 9'h00E);
      wr(1, 9'h012);
      idle(4);
      check(flags, 9'h00F);
      i_fifo_reader_model.read_words(3, 1'b0);
      check(i_fifo_reader_model.got_q[2], 9'h012);
      $display("programmed flags done");
      end_sim();
   end
endmodule : sync_fifo_prog_flags_bench
